// ==== logic/scc_freq_if.sv ====
// frequency selection fields and the resulting carrier word
`timescale 1ns/10ps
interface scc_freq_if;
	import scc_pkg::*;
	logic [2:0] band;
	logic [7:0] number;
	logic [4:0] channel;
	scc_freq_t freq;
	logic valid;
	modport calc (input band, input number, input channel, output freq, output valid);
	modport user (output band, output number, output channel, input freq, input valid);
endinterface : scc_freq_if

// ==== logic/scc_freq_word.sv ====
// carrier word from band, centre number and standard channel
`timescale 1ns/10ps
module scc_freq_word (
	// selection fields in, carrier out
	scc_freq_if.calc fp
);
	import scc_pkg::*;

	scc_freq_t fineNum;
	scc_freq_t coarseNum;
	scc_freq_t chanOff;
	assign fineNum = {6'h00, fp.number};
	assign coarseNum = 14'(fineNum * FREQ_COARSE_STEP);
	assign chanOff = 14'({9'h000, fp.channel - 5'h01} * FREQ_CH_STEP);

	// reserved settings drop valid so the last good carrier stays in use
	always_comb begin
		fp.freq = FREQ_CH0;
		fp.valid = 1'b0;
		case (fp.band)
			3'h0: begin
				if (fp.channel == 5'h00) begin
					fp.valid = 1'b1;
				end else if (fp.channel <= CH_MAX) begin
					fp.freq = FREQ_CH1 + chanOff;
					fp.valid = 1'b1;
				end
			end
			3'h1: begin
				fp.freq = FREQ_BAND1 + fineNum;
				fp.valid = 1'b1;
			end
			3'h2: begin
				fp.freq = FREQ_BAND2 + fineNum;
				fp.valid = 1'b1;
			end
			3'h3: begin
				fp.freq = FREQ_BAND3 + fineNum;
				fp.valid = 1'b1;
			end
			3'h4: begin
				fp.freq = FREQ_BAND4 + coarseNum;
				fp.valid = (fp.number <= NUM4_MAX);
			end
			3'h5: begin
				fp.freq = FREQ_BAND5 + coarseNum;
				fp.valid = (fp.number <= NUM5_MAX);
			end
			default: begin
				fp.valid = 1'b0;
			end
		endcase
	end
endmodule : scc_freq_word

// ==== logic/scc_pkg.sv ====
// shared constants and types for the synthesizer channel and calibration block
package scc_pkg;
	// core clock and the derived microsecond tick
	localparam int CLK_MHZ = 100;
	localparam int US_CYCLES = CLK_MHZ * 1;
	// register offsets
	localparam logic [7:0] ADDR_CHANNEL = 8'h08;
	localparam logic [7:0] ADDR_LOCK_STAT = 8'h11;
	localparam logic [7:0] ADDR_CNUM = 8'h13;
	localparam logic [7:0] ADDR_BAND = 8'h14;
	localparam logic [7:0] ADDR_CFCAL = 8'h1A;
	localparam logic [7:0] ADDR_DCUCAL = 8'h1B;
	// field positions
	localparam int CAL_START_POS = 7;
	localparam int LOCK_POS = 7;
	// values after reset
	localparam logic [2:0] CHAN_HI_RST = 3'h1;
	localparam logic [4:0] CHAN_RST = 5'h05;
	localparam logic [7:0] CNUM_RST = 8'h00;
	localparam logic [2:0] BAND_RST = 3'h0;
	localparam logic [1:0] CF_RSV_RST = 2'h2;
	localparam logic [4:0] TRIM_RST = 5'h00;
	localparam logic [6:0] DCU_RSV_RST = 7'h40;
	// times in microseconds, counted in microsecond ticks
	localparam int T_SETTLE_US = 200;
	localparam int T_CHAN_US = 11;
	localparam int T_TXTUNE_US = 16;
	localparam int T_RXTUNE_US = 32;
	localparam int T_CFSTEP_US = 8;
	localparam int T_DCU_US = 10;
	localparam int T_CFSTART_MAX_US = 25;
	// the same times as clock cycles
	localparam int DCU_CYC = T_DCU_US * US_CYCLES;
	localparam int CFSTART_MAX_CYC = T_CFSTART_MAX_US * US_CYCLES;
	// carrier frequencies in units of 100 kHz
	typedef logic [13:0] scc_freq_t;
	localparam scc_freq_t FREQ_CH0 = 14'h21EB;
	localparam scc_freq_t FREQ_CH1 = 14'h2364;
	localparam scc_freq_t FREQ_CH_STEP = 14'h0014;
	localparam scc_freq_t FREQ_BAND1 = 14'h1E0A;
	localparam scc_freq_t FREQ_BAND2 = 14'h217A;
	localparam scc_freq_t FREQ_BAND3 = 14'h2346;
	localparam scc_freq_t FREQ_BAND4 = 14'h1E0A;
	localparam scc_freq_t FREQ_BAND5 = 14'h208A;
	localparam scc_freq_t FREQ_COARSE_STEP = 14'h000A;
	localparam scc_freq_t FREQ_RX_OFFSET = 14'h000A;
	localparam logic [7:0] NUM4_MAX = 8'h5E;
	localparam logic [7:0] NUM5_MAX = 8'h66;
	localparam logic [4:0] CH_MAX = 5'h0A;
	// transceiver states seen by the synthesizer control
	typedef enum logic [2:0] {
		TRX_RADIO_OFF, TRX_SYNTH_IDLE, TRX_RX_LISTEN, TRX_AUTOACK_LISTEN,
		TRX_BUSY_RX, TRX_RECEIVING_AUTOACK, TRX_BUSY_TX, TRX_TRANSMITTING_RETRY
	} scc_trx_e;
endpackage : scc_pkg

// ==== logic/scc_synth_ctrl.sv ====
// synthesizer channel selection, calibration loops and lock tracking
`timescale 1ns/10ps
module scc_synth_ctrl (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// transceiver state and analog status
	input wire scc_pkg::scc_trx_e trxState,
	input wire logic vcoLocked,
	input wire logic [4:0] cfTarget,
	// interrupt flags and their clears
	output logic lockIrq,
	output logic unlockIrq,
	input wire logic lockIrqClr,
	input wire logic unlockIrqClr,
	// synthesizer control
	output scc_pkg::scc_freq_t rfFreq,
	output logic [4:0] cfTrim,
	output logic calBusy,
	output logic txRetuned,
	// state change requests to the transceiver
	output logic stateReqValid,
	output scc_pkg::scc_trx_e stateReq
);
	import scc_pkg::*;

	// microsecond tick so every timer shares one slow rate
	logic [6:0] divReg;
	logic usTick;
	assign usTick = (divReg == 7'(US_CYCLES - 1));
	always_ff @(posedge core_clk) begin
		if (!rst_n) divReg <= 7'h00;
		else divReg <= usTick ? 7'h00 : divReg + 7'h01;
	end

	// register decode
	logic wrChan, wrCnum, wrBand, wrCf, wrDcu, cfManualWr, dcuManualWr;
	assign wrChan = regWrEn && (regAddr == ADDR_CHANNEL);
	assign wrCnum = regWrEn && (regAddr == ADDR_CNUM);
	assign wrBand = regWrEn && (regAddr == ADDR_BAND);
	assign wrCf = regWrEn && (regAddr == ADDR_CFCAL);
	assign wrDcu = regWrEn && (regAddr == ADDR_DCUCAL);
	assign cfManualWr = wrCf && regWrData[CAL_START_POS];
	assign dcuManualWr = wrDcu && regWrData[CAL_START_POS];

	// plain storage registers; request bit 7 of channel is write-only
	logic [1:0] chanHiReg;
	logic [4:0] chanReg;
	logic [7:0] cnumReg;
	logic [2:0] bandReg;
	logic [1:0] cfRsvReg;
	logic [6:0] dcuRsvReg;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			chanHiReg <= CHAN_HI_RST[1:0];
			chanReg <= CHAN_RST;
			cnumReg <= CNUM_RST;
			bandReg <= BAND_RST;
			cfRsvReg <= CF_RSV_RST;
			dcuRsvReg <= DCU_RSV_RST;
		end else begin
			if (wrChan) begin
				chanHiReg <= regWrData[6:5];
				chanReg <= regWrData[4:0];
			end
			if (wrCnum) cnumReg <= regWrData;
			if (wrBand) bandReg <= regWrData[2:0];
			if (wrCf) cfRsvReg <= regWrData[6:5];
			if (wrDcu) dcuRsvReg <= regWrData[6:0];
		end
	end

	// carrier word from the selection fields
	scc_freq_if fw ();
	assign fw.band = bandReg;
	assign fw.number = cnumReg;
	assign fw.channel = chanReg;
	scc_freq_word uFreqWord (
		.fp(fw)
	);

	// transceiver state classes
	logic quiet, synthOn, txMode, rxBusy, enableEvt, setChange, calKick, cfGo, dcuGo;
	scc_trx_e trxPrevReg;
	scc_freq_t curFreqReg;
	assign quiet = (trxState == TRX_SYNTH_IDLE) || (trxState == TRX_RX_LISTEN)
		|| (trxState == TRX_AUTOACK_LISTEN);
	assign synthOn = (trxState != TRX_RADIO_OFF);
	assign txMode = (trxState == TRX_BUSY_TX) || (trxState == TRX_TRANSMITTING_RETRY);
	assign rxBusy = (trxState == TRX_BUSY_RX) || (trxState == TRX_RECEIVING_AUTOACK);
	assign enableEvt = (trxPrevReg == TRX_RADIO_OFF) && quiet;
	assign setChange = fw.valid && (fw.freq != curFreqReg);
	assign calKick = enableEvt || (setChange && synthOn);
	// manual starts honoured in every state, including busy ones
	assign cfGo = calKick || cfManualWr;
	assign dcuGo = calKick || dcuManualWr;

	// current carrier; a reserved setting keeps the previous one
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			trxPrevReg <= TRX_RADIO_OFF;
			curFreqReg <= FREQ_CH0;
		end else begin
			trxPrevReg <= trxState;
			if (fw.valid) curFreqReg <= fw.freq;
		end
	end

	// centre-frequency loop: one trim step toward the target per step time
	logic cfBusyReg, cfStartReg, cfStepEnd, cfDone;
	logic [2:0] cfStepReg;
	logic [4:0] cfAgeReg, trimReg, trimStep;
	assign cfStepEnd = cfBusyReg && usTick && (cfStepReg == 3'(T_CFSTEP_US - 1));
	assign trimStep = (trimReg < cfTarget) ? trimReg + 5'h01
		: (trimReg > cfTarget) ? trimReg - 5'h01 : trimReg;
	assign cfDone = cfStepEnd && (trimStep == cfTarget);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfBusyReg <= 1'b0;
			cfStepReg <= 3'h0;
			trimReg <= TRIM_RST;
		end else if (cfGo) begin
			cfBusyReg <= 1'b1;
			cfStepReg <= 3'h0;
			if (!cfBusyReg && wrCf) trimReg <= regWrData[4:0];
		end else begin
			if (cfBusyReg && usTick) cfStepReg <= cfStepEnd ? 3'h0 : cfStepReg + 3'h1;
			if (cfStepEnd) trimReg <= trimStep;
			else if (!cfBusyReg && wrCf) trimReg <= regWrData[4:0];
			if (cfDone) cfBusyReg <= 1'b0;
		end
	end

	// start bit drops at loop end or at the age limit, whichever first
	logic cfAgeEnd;
	assign cfAgeEnd = usTick && (cfAgeReg == 5'(T_CFSTART_MAX_US - 1));
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfStartReg <= 1'b0;
			cfAgeReg <= 5'h00;
		end else if (cfManualWr) begin
			cfStartReg <= 1'b1;
			cfAgeReg <= 5'h00;
		end else if (cfStartReg) begin
			if (cfDone || cfAgeEnd) cfStartReg <= 1'b0;
			if (usTick) cfAgeReg <= cfAgeReg + 5'h01;
		end
	end

	// delay-cell loop: fixed length, start bit clears on the finishing edge
	logic dcuBusyReg, dcuStartReg, dcuDone;
	logic [3:0] dcuCntReg;
	assign dcuDone = dcuBusyReg && usTick && (dcuCntReg == 4'(T_DCU_US - 1));
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dcuBusyReg <= 1'b0;
			dcuCntReg <= 4'h0;
			dcuStartReg <= 1'b0;
		end else begin
			if (dcuGo) begin
				dcuBusyReg <= 1'b1;
				dcuCntReg <= 4'h0;
			end else if (dcuDone) begin
				dcuBusyReg <= 1'b0;
			end else if (dcuBusyReg && usTick) begin
				dcuCntReg <= dcuCntReg + 4'h1;
			end
			if (dcuManualWr) dcuStartReg <= 1'b1;
			else if (dcuDone) dcuStartReg <= 1'b0;
		end
	end

	// settle timer: long after power-up, short after an in-band change
	logic [7:0] settleReg;
	logic chgUnlock;
	assign chgUnlock = setChange && quiet && !enableEvt;
	always_ff @(posedge core_clk) begin
		if (!rst_n) settleReg <= 8'h00;
		else if (enableEvt) settleReg <= 8'(T_SETTLE_US);
		else if (chgUnlock) settleReg <= 8'(T_CHAN_US);
		else if (usTick && settleReg != 8'h00) settleReg <= settleReg - 8'h01;
	end

	// lock tracking; a lock wait only ends once both loops are idle
	logic lockReg, lockWaitReg, relockWaitReg, vcoPrevReg;
	logic unexpected, waitEvt, relockEvt, lockEvt, unlockEvt, manUnlock;
	assign manUnlock = cfManualWr && quiet;
	assign unexpected = vcoPrevReg && !vcoLocked && lockReg && !lockWaitReg;
	assign waitEvt = lockWaitReg && (settleReg == 8'h00) && !cfBusyReg && !dcuBusyReg
		&& !cfGo && !dcuGo;
	assign relockEvt = relockWaitReg && vcoLocked && !lockWaitReg;
	assign lockEvt = waitEvt || relockEvt;
	assign unlockEvt = chgUnlock || manUnlock || unexpected;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lockReg <= 1'b0;
			lockWaitReg <= 1'b0;
			relockWaitReg <= 1'b0;
			vcoPrevReg <= 1'b0;
		end else begin
			vcoPrevReg <= vcoLocked;
			if (!synthOn) begin
				lockReg <= 1'b0;
				lockWaitReg <= 1'b0;
				relockWaitReg <= 1'b0;
			end else begin
				if (enableEvt || chgUnlock || cfManualWr) lockWaitReg <= 1'b1;
				else if (waitEvt) lockWaitReg <= 1'b0;
				if (unexpected) relockWaitReg <= 1'b1;
				else if (relockEvt || lockWaitReg) relockWaitReg <= 1'b0;
				if (unlockEvt) lockReg <= 1'b0;
				else if (lockEvt) lockReg <= 1'b1;
			end
		end
	end

	// pending flags; a raise beats a clear in the same cycle
	logic lockIrqReg, unlockIrqReg;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lockIrqReg <= 1'b0;
			unlockIrqReg <= 1'b0;
		end else if (lockEvt) begin
			lockIrqReg <= 1'b1;
			unlockIrqReg <= 1'b0;
		end else if (unlockEvt) begin
			unlockIrqReg <= 1'b1;
			lockIrqReg <= 1'b0;
		end else begin
			if (lockIrqClr) lockIrqReg <= 1'b0;
			if (unlockIrqClr) unlockIrqReg <= 1'b0;
		end
	end

	// state requests on lock loss and on relock
	logic stateReqValidReg;
	scc_trx_e stateReqReg;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stateReqValidReg <= 1'b0;
			stateReqReg <= TRX_SYNTH_IDLE;
		end else begin
			stateReqValidReg <= 1'b0;
			if (unexpected && txMode) begin
				stateReqValidReg <= 1'b1;
				stateReqReg <= TRX_SYNTH_IDLE;
			end else if (relockEvt && rxBusy) begin
				stateReqValidReg <= 1'b1;
				stateReqReg <= (trxState == TRX_BUSY_RX) ? TRX_RX_LISTEN : TRX_AUTOACK_LISTEN;
			end
		end
	end

	// transmit shift: no lock bookkeeping touched, so no interrupts follow
	logic txPrevReg, txRetunedReg;
	logic [5:0] shiftReg;
	scc_freq_t rfFreqReg;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			txPrevReg <= 1'b0;
			shiftReg <= 6'h00;
			txRetunedReg <= 1'b0;
			rfFreqReg <= FREQ_CH0 - FREQ_RX_OFFSET;
		end else begin
			txPrevReg <= txMode;
			if (txMode && !txPrevReg) shiftReg <= 6'(T_TXTUNE_US);
			else if (!txMode && txPrevReg) shiftReg <= 6'(T_RXTUNE_US);
			else if (usTick && shiftReg != 6'h00) shiftReg <= shiftReg - 6'h01;
			txRetunedReg <= txMode && txPrevReg && (shiftReg == 6'h00);
			rfFreqReg <= txMode ? curFreqReg : curFreqReg - FREQ_RX_OFFSET;
		end
	end

	// read mux; unmapped offsets read zero
	logic [7:0] rdMux;
	logic calBusyReg;
	logic [7:0] rdDataReg;
	assign rdMux = (regAddr == ADDR_CHANNEL) ? {1'b0, chanHiReg, chanReg}
		: (regAddr == ADDR_LOCK_STAT) ? {lockReg, 7'h00}
		: (regAddr == ADDR_CNUM) ? cnumReg
		: (regAddr == ADDR_BAND) ? {5'h00, bandReg}
		: (regAddr == ADDR_CFCAL) ? {cfStartReg, cfRsvReg, trimReg}
		: (regAddr == ADDR_DCUCAL) ? {dcuStartReg, dcuRsvReg} : 8'h00;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdDataReg <= 8'h00;
			calBusyReg <= 1'b0;
		end else begin
			if (regRdEn) rdDataReg <= rdMux;
			calBusyReg <= cfBusyReg || dcuBusyReg;
		end
	end

	assign regRdData = rdDataReg;
	assign lockIrq = lockIrqReg;
	assign unlockIrq = unlockIrqReg;
	assign rfFreq = rfFreqReg;
	assign cfTrim = trimReg;
	assign calBusy = calBusyReg;
	assign txRetuned = txRetunedReg;
	assign stateReqValid = stateReqValidReg;
	assign stateReq = stateReqReg;

	// cycle counters that only the checks read
	int dcuCycReg, cfStartCycReg;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dcuCycReg <= 0;
			cfStartCycReg <= 0;
		end else begin
			// zero on the kick so the count equals the busy cycles exactly
			dcuCycReg <= dcuGo ? 0 : dcuBusyReg ? dcuCycReg + 1 : dcuCycReg;
			cfStartCycReg <= cfStartReg ? cfStartCycReg + 1 : 0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_lockClearsUnlock;
		lockEvt |=> lockIrqReg && !unlockIrqReg;
	endproperty
	a_lockClearsUnlock: assert property (p_lockClearsUnlock)
		else $error("lock raise left unlock pending");

	property p_unlockClearsLock;
		(unlockEvt && !lockEvt) |=> unlockIrqReg && !lockIrqReg;
	endproperty
	a_unlockClearsLock: assert property (p_unlockClearsLock)
		else $error("unlock raise left lock pending");

	property p_manualUnlock;
		(cfManualWr && quiet && !lockEvt) |=> unlockIrqReg && cfStartReg && cfBusyReg;
	endproperty
	a_manualUnlock: assert property (p_manualUnlock)
		else $error("manual centre start gave no unlock");

	property p_dcuLength;
		$fell(dcuBusyReg) |-> (dcuCycReg > DCU_CYC - US_CYCLES) && (dcuCycReg <= DCU_CYC)
			&& !dcuStartReg;
	endproperty
	a_dcuLength: assert property (p_dcuLength)
		else $error("delay calibration length wrong");

	property p_cfStartAge;
		cfStartCycReg <= CFSTART_MAX_CYC;
	endproperty
	a_cfStartAge: assert property (p_cfStartAge)
		else $error("centre start bit held too long");

	property p_txAbort;
		(unexpected && txMode) |=> stateReqValidReg && (stateReqReg == TRX_SYNTH_IDLE)
			&& unlockIrqReg;
	endproperty
	a_txAbort: assert property (p_txAbort)
		else $error("lock loss in transmit not aborted");

	property p_enableSettle;
		enableEvt |=> (settleReg == 8'(T_SETTLE_US)) && cfBusyReg && dcuBusyReg && !lockReg;
	endproperty
	a_enableSettle: assert property (p_enableSettle)
		else $error("enable did not start settle and calibration");

	property p_channelZero;
		(bandReg == 3'h0 && chanReg == 5'h00) [*2] |-> curFreqReg == FREQ_CH0;
	endproperty
	a_channelZero: assert property (p_channelZero)
		else $error("channel zero carrier wrong");

	property p_rxOffset;
		(!txMode) [*2] |-> rfFreqReg == $past(curFreqReg) - FREQ_RX_OFFSET;
	endproperty
	a_rxOffset: assert property (p_rxOffset)
		else $error("receive carrier not 1 MHz below");

	property p_shiftQuiet;
		($changed(txMode) && synthOn && !lockEvt && !unlockEvt && !lockIrqClr
			&& !unlockIrqClr) |=> $stable(lockIrqReg) && $stable(unlockIrqReg)
			&& $stable(lockReg);
	endproperty
	a_shiftQuiet: assert property (p_shiftQuiet)
		else $error("transmit shift raised an interrupt");

	c_lockEvt: cover property (lockEvt);
	c_relock: cover property (relockEvt && rxBusy);
	c_dcuDone: cover property (dcuDone && dcuStartReg);
	c_cfDone: cover property (cfDone && cfStartReg);
endmodule : scc_synth_ctrl

// ==== tb/scc_host_model.sv ====
// host model driving the parallel register port
`timescale 1ns/10ps
module scc_host_model (
	// clock
	input wire logic core_clk,
	// register port
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic [7:0] regWrData,
	output logic regRdEn,
	input wire logic [7:0] regRdData
);
	import scc_pkg::*;
	// quiet port at time zero
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end
	// one-cycle write; address and data flip afterwards so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk);
		regAddr = a;
		regWrData = v;
		regWrEn = 1'b1;
		@(negedge core_clk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~v;
	endtask : wr
	// read strobe; registered data taken at the next falling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge core_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge core_clk);
		v = regRdData;
		regRdEn = 1'b0;
		regAddr = ~a;
	endtask : rd
	// manual recalibration keeps trim and reserved bits as read
	task automatic cf_kick();
		logic [7:0] v;
		rd(ADDR_CFCAL, v);
		wr(ADDR_CFCAL, v | 8'h80);
	endtask : cf_kick
endmodule : scc_host_model

// ==== tb/scc_synth_ctrl_tb.sv ====
// self-checking bench for synthesizer channel and calibration control
`timescale 1ns/10ps
module scc_synth_ctrl_tb;
	import scc_pkg::*;
	typedef struct {logic [2:0] band; logic [7:0] num; logic [4:0] ch; scc_freq_t f;} scc_row_s;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic regWrEn;
	logic regRdEn;
	scc_trx_e trxState = TRX_RADIO_OFF;
	logic vcoLocked = 1'b1;
	logic [4:0] cfTarget = 5'h00;
	logic lockIrq;
	logic unlockIrq;
	logic lockIrqClr = 1'b0;
	logic unlockIrqClr = 1'b0;
	scc_freq_t rfFreq;
	logic [4:0] cfTrim;
	logic calBusy;
	logic txRetuned;
	logic stateReqValid;
	scc_trx_e stateReq;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	int t;
	logic [7:0] d;
	// band, number, channel, carrier in 100 kHz units
	scc_row_s rows [7] = '{'{3'h1, 8'hFF, 5'h0A, 14'h1F09}, '{3'h2, 8'h00, 5'h0A, 14'h217A},
		'{3'h3, 8'h0A, 5'h0A, 14'h2350}, '{3'h4, 8'h5E, 5'h0A, 14'h21B6},
		'{3'h5, 8'h66, 5'h0A, 14'h2486}, '{3'h0, 8'h33, 5'h00, 14'h21EB},
		'{3'h0, 8'h33, 5'h0A, 14'h2418}};
	// offset and value after reset; 0x20 is unmapped
	logic [15:0] rstTab [7] = '{16'h0825, 16'h1300, 16'h1400, 16'h1A40, 16'h1B40, 16'h1100,
		16'h2000};
	scc_synth_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.trxState(trxState), .vcoLocked(vcoLocked), .cfTarget(cfTarget), .lockIrq(lockIrq),
		.unlockIrq(unlockIrq), .lockIrqClr(lockIrqClr), .unlockIrqClr(unlockIrqClr),
		.rfFreq(rfFreq), .cfTrim(cfTrim), .calBusy(calBusy), .txRetuned(txRetuned),
		.stateReqValid(stateReqValid), .stateReq(stateReq));
	scc_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
	// 100 MHz clock
	always #5 core_clk = ~core_clk;
	// hang guard, well above the roughly 26k cycles the run needs
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures++;
			tally_and_finish();
		end
	end
	// compare and report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for the lock flag
	task automatic wait_lock(output int k);
		for (k = 0; k < 30000 && lockIrq !== 1'b1; k++) @(negedge core_clk);
	endtask : wait_lock
	// bounded wait for a state change request
	task automatic wait_req();
		for (n = 0; n < 20 && stateReqValid !== 1'b1; n++) @(negedge core_clk);
	endtask : wait_req
	// verdict
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial begin
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		@(negedge core_clk);
		trxState = TRX_SYNTH_IDLE;
		wait_lock(n);
		chk({n >= 20000, lockIrq, unlockIrq}, 3'b110); // settle
		host.rd(ADDR_LOCK_STAT, d);
		chk(d, 8'h80); // lock bit
		$display("test enable done");
		// receive carrier sits 1 MHz below the computed one
		foreach (rows[i]) begin
			host.wr(ADDR_BAND, {5'h00, rows[i].band});
			host.wr(ADDR_CNUM, rows[i].num);
			host.wr(ADDR_CHANNEL, {3'h1, rows[i].ch});
			host.rd(ADDR_CHANNEL, d);
			chk(d, {3'h1, rows[i].ch}); // readback
			chk(rfFreq, rows[i].f - 14'h000A); // carrier
		end
		$display("test table done");
		host.wr(ADDR_BAND, 8'h06);
		repeat (3) @(negedge core_clk);
		chk(rfFreq, 14'h240E); // reserved band keeps carrier
		host.wr(ADDR_BAND, 8'h00);
		wait_lock(n);
		host.wr(ADDR_CHANNEL, 8'h21);
		repeat (2) @(negedge core_clk);
		chk({lockIrq, unlockIrq, calBusy}, 3'b011);
		wait_lock(n);
		chk({n >= 1090, n < 3000, unlockIrq}, 3'b110); // hop time
		$display("test hop done");
		cfTarget = 5'h03;
		host.cf_kick(); // centre kick
		host.wr(ADDR_DCUCAL, 8'h80); // concurrent
		chk(unlockIrq, 1'b1);
		t = 0;
		do begin
			host.rd(ADDR_DCUCAL, d);
			t += 2;
		end while (d[7] === 1'b1 && t < 2000);
		chk({t >= 880, t <= 1010, d[7]}, 3'b110); // delay loop end
		wait_lock(n);
		chk({n + t >= 2390, n + t <= 27000, cfTrim}, {2'b11, 5'h03}); // steps
		host.rd(ADDR_CFCAL, d);
		chk(d, 8'h43); // start bit cleared
		$display("test calibration done");
		host.wr(ADDR_CHANNEL, 8'h2B);
		repeat (2) @(negedge core_clk);
		chk({rfFreq, unlockIrq}, {14'h235A, 1'b0}); // reserved channel keeps carrier
		trxState = TRX_BUSY_TX;
		repeat (2) @(negedge core_clk);
		chk({rfFreq, txRetuned}, {14'h2364, 1'b0}); // transmit carrier
		repeat (1700) @(negedge core_clk);
		chk({txRetuned, lockIrq, unlockIrq}, 3'b110); // retune, no new flags
		vcoLocked = 1'b0;
		wait_req();
		chk({stateReqValid, stateReq, unlockIrq}, {1'b1, TRX_SYNTH_IDLE, 1'b1});
		trxState = TRX_SYNTH_IDLE;
		vcoLocked = 1'b1;
		repeat (3) @(negedge core_clk);
		chk({rfFreq, lockIrq}, {14'h235A, 1'b1}); // relock
		$display("test transmit done");
		for (int i = 0; i < 2; i++) begin
			trxState = i ? TRX_RECEIVING_AUTOACK : TRX_BUSY_RX;
			repeat (3) @(negedge core_clk);
			vcoLocked = 1'b0;
			repeat (3) @(negedge core_clk);
			vcoLocked = 1'b1;
			wait_req();
			chk({stateReqValid, stateReq},
				{1'b1, i ? TRX_AUTOACK_LISTEN : TRX_RX_LISTEN});
			trxState = i ? TRX_AUTOACK_LISTEN : TRX_RX_LISTEN;
			@(negedge core_clk);
		end
		// lock loss in the retrying transmit state aborts as well
		trxState = TRX_TRANSMITTING_RETRY;
		repeat (3) @(negedge core_clk);
		vcoLocked = 1'b0;
		wait_req();
		chk({stateReqValid, stateReq}, {1'b1, TRX_SYNTH_IDLE}); // retry abort
		trxState = TRX_SYNTH_IDLE;
		vcoLocked = 1'b1;
		repeat (3) @(negedge core_clk);
		$display("test receive done");
		lockIrqClr = 1'b1;
		@(negedge core_clk);
		lockIrqClr = 1'b0;
		@(negedge core_clk);
		chk(lockIrq, 1'b0); // flag clear
		host.wr(ADDR_LOCK_STAT, 8'h00);
		host.rd(ADDR_LOCK_STAT, d);
		chk(d, 8'h80); // read-only
		$display("test flags done");
		trxState = TRX_RADIO_OFF;
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		foreach (rstTab[i]) begin
			host.rd(rstTab[i][15:8], d);
			chk(d, rstTab[i][7:0]); // reset values
		end
		chk({lockIrq, unlockIrq, calBusy, stateReqValid}, 4'h0);
		$display("test reset done");
		tally_and_finish();
	end
endmodule : scc_synth_ctrl_tb
